/* File: cfg_device.sv */
// Device end of the parallel configuration link and its word FIFO.
// Assumes the host end drives request, clock, width and data pins.
`timescale 1ns/10ps
`default_nettype none
`include "cfg_load_params.svh"

module cfg_word_fifo #(
	parameter int W = `WORD_W,
	parameter int D = `FIFO_DEPTH
) (
	input  wire logic         clk_sys_i,
	input  wire logic         rstn_i,
	input  wire logic         flush_i,
	input  wire logic [W-1:0] in_data_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	output logic [W-1:0]      out_data_o,
	output logic              out_valid_o,
	input  wire logic         out_ready_i
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0]  wr_ptr;
	logic [AW:0]  rd_ptr;

	assign in_ready_o = (wr_ptr - rd_ptr) != (AW+1)'(D);
	assign out_valid_o = wr_ptr != rd_ptr;
	assign out_data_o = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge clk_sys_i) begin
		if (in_valid_i && in_ready_o)
			mem[wr_ptr[AW-1:0]] <= in_data_i;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i || flush_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (in_valid_i && in_ready_o)
				wr_ptr <= wr_ptr + 1'b1;
			if (out_valid_o && out_ready_i)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule

// Operation
// - User mode idles request, health, done high
// - Health held low through power-on delay
// - Load-complete low until image fully loaded
// - Request low pulls load-complete low quickly
// - Request low pulls health low quickly
// - Host holds request low two microseconds
// - Health low between 268 and 1506 us
// - Health released within 1506 us of request
// - Host waits after health before clocking
// - Host clock within 125/100 MHz limit
// - Width selects which data lines carry image
// - Data lines become user I/O after load
// - Host sends every image word
// - Load-complete rises only on error-free image
// - Two extra falling edges start initialisation
// - Oscillator init takes 175 to 437 us
// - User-clock init waits then 8576 edges
// - Init-complete driven low until init ends
// - Clock ignored after load, never floating
// - Timing assumes decompression and security off
// - One clock edge per word here
module cfg_device #(
	parameter int unsigned POR_CYC = `POR_DELAY_US * `CLK_MHZ,
	parameter int unsigned HEALTH_MIN_CYC = `HEALTH_LOW_MIN_US * `CLK_MHZ,
	parameter int unsigned INIT_OSC_CYC = `INIT_OSC_MIN_US * `CLK_MHZ,
	parameter int unsigned USER_EDGES = `USER_CLK_EDGES,
	parameter int unsigned IMAGE_WORDS = `IMAGE_WORDS
) (
	input  wire logic        clk_sys_i,
	input  wire logic        rstn_i,
	cfg_link_if.device       link,
	input  wire logic        use_user_clock_i,
	input  wire logic        init_done_en_i,
	input  wire logic        user_init_clock_i,
	output logic [31:0]      image_word_o,
	output logic             image_valid_o,
	input  wire logic        image_ready_i,
	input  wire logic [31:0] gpio_out_i,
	input  wire logic        gpio_oe_i,
	output logic [31:0]      gpio_in_o,
	output logic             user_mode_o,
	output logic             error_o
);
	localparam int unsigned USER_WAIT_CYC = (`USER_CLK_WAIT_PER *
		`CFG_CLK_MAX_PER_NS * `CLK_MHZ + 999) / 1000;

	cfg_load_pkg::dev_state_t state;
	cfg_load_pkg::dev_state_t next_state;
	logic [37:0] sync1;
	logic [37:0] sync2;
	logic        clk_prev;
	logic        uclk_prev;
	logic [31:0] cnt;
	logic [31:0] edges;
	logic [31:0] words;
	logic [1:0]  width;
	logic        push_ready;
	logic        push;
	logic        req_n_s;
	logic        clk_s;
	logic        health_s;
	logic        uclk_s;
	logic [31:0] data_s;
	logic        clk_rise;
	logic        clk_fall;
	logic        uclk_rise;

	function automatic logic [31:0] mask_word(input logic [1:0] w,
		input logic [31:0] d);
		if (w == `WIDTH_X8)
			mask_word = {24'h000000, d[7:0]};
		else if (w == `WIDTH_X16)
			mask_word = {16'h0000, d[15:0]};
		else
			mask_word = d;
	endfunction

	// Pin synchronisers
	always_ff @(posedge clk_sys_i) begin
		sync1 <= {link.config_request_n, link.cfg_clock, link.cfg_health_n,
			user_init_clock_i, link.width_sel, link.data};
		sync2 <= sync1;
		clk_prev <= sync2[36];
		uclk_prev <= sync2[34];
	end

	assign req_n_s = sync2[37];
	assign clk_s = sync2[36];
	assign health_s = sync2[35];
	assign uclk_s = sync2[34];
	assign data_s = sync2[31:0];
	assign clk_rise = clk_s && !clk_prev;
	assign clk_fall = !clk_s && clk_prev;
	assign uclk_rise = uclk_s && !uclk_prev;
	// Capture one word per rising edge while loading
	assign push = state == cfg_load_pkg::DEV_LOAD && clk_rise && health_s;

	always_comb begin
		next_state = state;
		case (state)
			cfg_load_pkg::DEV_POR: begin
				if (cnt >= POR_CYC - 1)
					next_state = cfg_load_pkg::DEV_RESET;
			end
			cfg_load_pkg::DEV_RESET: begin
				if (cnt >= HEALTH_MIN_CYC - 1 && req_n_s)
					next_state = cfg_load_pkg::DEV_LOAD;
			end
			cfg_load_pkg::DEV_LOAD: begin
				if (push && !push_ready)
					next_state = cfg_load_pkg::DEV_RESET;
				else if (words == IMAGE_WORDS)
					next_state = cfg_load_pkg::DEV_TAIL;
			end
			cfg_load_pkg::DEV_TAIL: begin
				if (edges == `EXTRA_FALL_EDGES)
					next_state = cfg_load_pkg::DEV_INIT;
			end
			cfg_load_pkg::DEV_INIT: begin
				if (!use_user_clock_i && cnt >= INIT_OSC_CYC - 1)
					next_state = cfg_load_pkg::DEV_USER;
				else if (use_user_clock_i && edges == USER_EDGES)
					next_state = cfg_load_pkg::DEV_USER;
			end
			default: begin
				next_state = cfg_load_pkg::DEV_USER;
			end
		endcase
		// Request low restarts from any state but power-up
		if (!req_n_s && state != cfg_load_pkg::DEV_POR)
			next_state = cfg_load_pkg::DEV_RESET;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i)
			state <= cfg_load_pkg::DEV_POR;
		else
			state <= next_state;
	end

	// Cycle counter, restarted on each state change or held request
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i || next_state != state || !req_n_s)
			cnt <= '0;
		else if (cnt != 32'hffffffff)
			cnt <= cnt + 1'b1;
	end

	// Falling edges after load, then user clock edges
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i || next_state != state)
			edges <= '0;
		else if (state == cfg_load_pkg::DEV_TAIL && clk_fall)
			edges <= edges + 1'b1;
		else if (state == cfg_load_pkg::DEV_INIT && use_user_clock_i &&
			cnt >= USER_WAIT_CYC && uclk_rise)
			edges <= edges + 1'b1;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i || state != cfg_load_pkg::DEV_LOAD)
			words <= '0;
		else if (image_valid_o && image_ready_i)
			words <= words + 1'b1;
	end

	// Width strap caught as loading starts
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i)
			width <= `WIDTH_X32;
		else if (state == cfg_load_pkg::DEV_RESET)
			width <= sync2[33:32];
	end

	// Overflow means a lost word, so the load fails
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i || (state == cfg_load_pkg::DEV_RESET && !req_n_s))
			error_o <= 1'b0;
		else if (push && !push_ready)
			error_o <= 1'b1;
	end

	cfg_word_fifo #(
		.W(`WORD_W),
		.D(`FIFO_DEPTH)
	) u_fifo (
		.clk_sys_i   (clk_sys_i),
		.rstn_i      (rstn_i),
		.flush_i     (state != cfg_load_pkg::DEV_LOAD),
		.in_data_i   (mask_word(width, data_s)),
		.in_valid_i  (push),
		.in_ready_o  (push_ready),
		.out_data_o  (image_word_o),
		.out_valid_o (image_valid_o),
		.out_ready_i (image_ready_i)
	);

	// User-mode pins and general I/O
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			link.dev_data_o <= 32'h00000000;
			link.dev_data_oe_n <= 1'b1;
			gpio_in_o <= 32'h00000000;
		end else begin
			link.dev_data_o <= gpio_out_i;
			link.dev_data_oe_n <= !(state == cfg_load_pkg::DEV_USER &&
				gpio_oe_i);
			gpio_in_o <= state == cfg_load_pkg::DEV_USER ? data_s :
				32'h00000000;
		end
	end

	assign link.dev_health_o = 1'b0;
	assign link.dev_health_oe_n = !(state == cfg_load_pkg::DEV_POR ||
		state == cfg_load_pkg::DEV_RESET);
	assign link.dev_load_complete_o = 1'b0;
	assign link.dev_load_complete_oe_n = !(state == cfg_load_pkg::DEV_POR ||
		state == cfg_load_pkg::DEV_RESET ||
		state == cfg_load_pkg::DEV_LOAD);
	assign link.dev_init_done_o = 1'b0;
	assign link.dev_init_done_oe_n = !(init_done_en_i &&
		(state == cfg_load_pkg::DEV_TAIL ||
		state == cfg_load_pkg::DEV_INIT));
	assign user_mode_o = state == cfg_load_pkg::DEV_USER;
endmodule
`default_nettype wire

/* File: cfg_host.sv */
// Host end of the parallel configuration link: drives request, clock, data.
// Assumes a word source on the user side and the device end on the link.
`timescale 1ns/10ps
`default_nettype none
`include "cfg_load_params.svh"
module cfg_host #(
	parameter int unsigned BLIND_WAIT_CYC = `REQ_HIGH_TO_CLK_US * `CLK_MHZ
) (
	input  wire logic        clk_sys_i,
	input  wire logic        rstn_i,
	cfg_link_if.host         link,
	input  wire logic        start_i,
	input  wire logic [1:0]  width_sel_i,
	input  wire logic        watch_health_i,
	input  wire logic        hold_health_i,
	input  wire logic [31:0] src_word_i,
	input  wire logic        src_valid_i,
	output logic             src_ready_o,
	output logic             busy_o,
	output logic             done_o,
	output logic             fault_o
);
	localparam int unsigned REQ_LOW_CYC = `REQ_LOW_MIN_US * `CLK_MHZ;
	localparam int unsigned SETTLE_CYC = `HEALTH_TO_CLK_US * `CLK_MHZ;

	cfg_load_pkg::host_state_t state;
	logic [2:0]  sync1;
	logic [2:0]  sync2;
	logic [31:0] cnt;
	logic [2:0]  half;
	logic [1:0]  falls;
	logic        have;
	logic        tick;
	logic        health_s;
	logic        lc_s;

	always_ff @(posedge clk_sys_i) begin
		sync1 <= {link.cfg_health_n, link.load_complete, link.init_complete};
		sync2 <= sync1;
	end

	assign health_s = sync2[2];
	assign lc_s = sync2[1];
	assign tick = half == 3'(`CFG_HALF_CYC - 1);
	assign src_ready_o = state == cfg_load_pkg::HOST_SEND && !have;
	assign busy_o = state != cfg_load_pkg::HOST_IDLE &&
		state != cfg_load_pkg::HOST_DONE;
	assign done_o = state == cfg_load_pkg::HOST_DONE;

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			state <= cfg_load_pkg::HOST_IDLE;
			cnt <= '0;
			fault_o <= 1'b0;
		end else begin
			cnt <= cnt + 1'b1;
			case (state)
				cfg_load_pkg::HOST_IDLE, cfg_load_pkg::HOST_DONE: begin
					if (start_i) begin
						state <= cfg_load_pkg::HOST_REQ;
						fault_o <= 1'b0;
						cnt <= '0;
					end
				end
				cfg_load_pkg::HOST_REQ: begin
					if (cnt >= REQ_LOW_CYC - 1) begin
						state <= cfg_load_pkg::HOST_WAIT;
						cnt <= '0;
					end
				end
				cfg_load_pkg::HOST_WAIT: begin
					if (watch_health_i && !health_s)
						cnt <= '0;
					if ((watch_health_i && health_s && cnt >= SETTLE_CYC) ||
						(!watch_health_i && cnt >= BLIND_WAIT_CYC))
						state <= cfg_load_pkg::HOST_SEND;
				end
				cfg_load_pkg::HOST_SEND: begin
					if (!health_s) begin
						state <= cfg_load_pkg::HOST_IDLE;
						fault_o <= 1'b1;
					end else if (lc_s && !link.cfg_clock)
						state <= cfg_load_pkg::HOST_TAIL;
				end
				cfg_load_pkg::HOST_TAIL: begin
					if (falls == 2'(`EXTRA_FALL_EDGES))
						state <= cfg_load_pkg::HOST_DONE;
				end
				default: begin
					state <= cfg_load_pkg::HOST_IDLE;
				end
			endcase
		end
	end

	// Divided clock: one word per period, well under the limit
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i || (state != cfg_load_pkg::HOST_SEND &&
			state != cfg_load_pkg::HOST_TAIL)) begin
			half <= '0;
			link.cfg_clock <= 1'b0;
			have <= 1'b0;
			falls <= '0;
		end else if (src_valid_i && src_ready_o) begin
			half <= '0;
			have <= 1'b1;
		end else if (!tick) begin
			half <= half + 1'b1;
		end else begin
			half <= '0;
			if (link.cfg_clock) begin
				link.cfg_clock <= 1'b0;
				have <= 1'b0;
				if (state == cfg_load_pkg::HOST_TAIL)
					falls <= falls + 1'b1;
			end else if (have || state == cfg_load_pkg::HOST_TAIL) begin
				link.cfg_clock <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			link.host_data_o <= 32'h00000000;
			link.width_sel <= `WIDTH_X32;
		end else begin
			if (src_valid_i && src_ready_o)
				link.host_data_o <= src_word_i;
			link.width_sel <= width_sel_i;
		end
	end

	// Data released once the extra falling edges after load complete are sent
	assign link.host_data_oe_n = !(state == cfg_load_pkg::HOST_SEND ||
		state == cfg_load_pkg::HOST_TAIL);
	assign link.config_request_n = state != cfg_load_pkg::HOST_REQ;
	assign link.host_health_oe_n = !hold_health_i;
endmodule
`default_nettype wire

/* File: cfg_link_chk.sv */
// Checker of the configuration link wires.
// Assumes both ends share clk_sys_i and rstn_i.
`timescale 1ns/10ps
`default_nettype none
module cfg_link_chk #(
	parameter int POR_CYC  = 20,
	parameter int HMIN_CYC = 50,
	parameter int HMAX_CYC = 281,
	parameter int WORDS    = 64,
	parameter int INIT_MIN = 40
) (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic config_request_n,
	input wire logic cfg_clock,
	input wire logic cfg_health_n,
	input wire logic load_complete,
	input wire logic init_complete,
	input wire logic host_data_oe_n,
	input wire logic dev_data_oe_n,
	input wire logic host_health_oe_n,
	input wire logic dev_init_done_oe_n
);
	localparam int RESP_CYC = 60;
	logic [15:0] por_cnt;
	logic [15:0] lo_cnt;
	logic [15:0] hi_cnt;
	logic [15:0] lc_cnt;
	logic [15:0] wcnt;
	logic        armed;
	logic        clk_q;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);
	// Time since reset release
	always_ff @(posedge clk_sys_i) begin
		por_cnt <= !rstn_i ? '0 : por_cnt + 16'h1;
	end
	// Health low run lengths
	always_ff @(posedge clk_sys_i) begin
		lo_cnt <= (!rstn_i || cfg_health_n) ? '0 : lo_cnt + 16'h1;
		hi_cnt <= (!rstn_i || cfg_health_n || !config_request_n ||
			!host_health_oe_n) ? '0 : hi_cnt + 16'h1;
		armed <= rstn_i && (armed || !config_request_n);
	end
	// Words clocked in and time since load complete
	always_ff @(posedge clk_sys_i) begin
		clk_q <= cfg_clock;
		lc_cnt <= (!rstn_i || !load_complete) ? '0 : lc_cnt + 16'h1;
		if (!rstn_i || !config_request_n)
			wcnt <= '0;
		else if (!clk_q && cfg_clock && cfg_health_n && !load_complete)
			wcnt <= wcnt + 16'h1;
	end
	property p_resp_lc;
		$fell(config_request_n) |-> ##[0:RESP_CYC] !load_complete;
	endproperty
	a_resp_lc: assert property (p_resp_lc)
		else $error("load complete slow to fall");
	property p_resp_hl;
		$fell(config_request_n) |-> ##[0:RESP_CYC] !cfg_health_n;
	endproperty
	a_resp_hl: assert property (p_resp_hl)
		else $error("health slow to fall");
	property p_por;
		por_cnt < POR_CYC |-> !cfg_health_n;
	endproperty
	a_por: assert property (p_por)
		else $error("health high during power-on delay");
	property p_health_min;
		$rose(cfg_health_n) && armed |-> lo_cnt >= HMIN_CYC;
	endproperty
	a_health_min: assert property (p_health_min)
		else $error("health low too short");
	property p_health_rel;
		!cfg_health_n |-> hi_cnt <= HMAX_CYC;
	endproperty
	a_health_rel: assert property (p_health_rel)
		else $error("health held too long");
	property p_lc_low;
		!cfg_health_n |-> !load_complete;
	endproperty
	a_lc_low: assert property (p_lc_low)
		else $error("load complete high during reset");
	property p_lc_words;
		$rose(load_complete) |-> wcnt == WORDS;
	endproperty
	a_lc_words: assert property (p_lc_words)
		else $error("load complete on wrong word count");
	property p_lc_hold;
		load_complete && config_request_n |=> load_complete;
	endproperty
	a_lc_hold: assert property (p_lc_hold)
		else $error("load complete dropped without request");
	property p_init_time;
		$rose(init_complete) |-> lc_cnt >= INIT_MIN;
	endproperty
	a_init_time: assert property (p_init_time)
		else $error("init finished too early");
	property p_init_lc;
		!dev_init_done_oe_n |-> load_complete;
	endproperty
	a_init_lc: assert property (p_init_lc)
		else $error("init pulled low before load");
	property p_data_user;
		!dev_data_oe_n |-> host_data_oe_n && init_complete;
	endproperty
	a_data_user: assert property (p_data_user)
		else $error("device drives data outside user mode");
	c_load: cover property ($rose(load_complete));
	c_init: cover property ($rose(init_complete));
	c_gpio: cover property (!dev_data_oe_n);
endmodule
`default_nettype wire

/* File: cfg_link_if.sv */
// Pins between configuration host and device, with wire resolution.
// Open-drain lines float high unless some end pulls them low.
`timescale 1ns/10ps
`default_nettype none
interface cfg_link_if;
	logic        config_request_n;
	logic        cfg_clock;
	logic [1:0]  width_sel;
	logic [31:0] host_data_o;
	logic        host_data_oe_n;
	logic [31:0] dev_data_o;
	logic        dev_data_oe_n;
	logic        dev_health_o;
	logic        dev_health_oe_n;
	logic        host_health_oe_n;
	logic        dev_load_complete_o;
	logic        dev_load_complete_oe_n;
	logic        dev_init_done_o;
	logic        dev_init_done_oe_n;
	logic [31:0] data;
	logic        cfg_health_n;
	logic        load_complete;
	logic        init_complete;

	assign data = !host_data_oe_n ? host_data_o :
		(!dev_data_oe_n ? dev_data_o : 32'hffffffff);
	assign cfg_health_n = !((!dev_health_oe_n && !dev_health_o) ||
		!host_health_oe_n);
	assign load_complete = dev_load_complete_oe_n || dev_load_complete_o;
	assign init_complete = dev_init_done_oe_n || dev_init_done_o;

	modport device (
		input  config_request_n, cfg_clock, width_sel, data,
		input  cfg_health_n,
		output dev_data_o, dev_data_oe_n, dev_health_o, dev_health_oe_n,
		output dev_load_complete_o, dev_load_complete_oe_n,
		output dev_init_done_o, dev_init_done_oe_n
	);
	modport host (
		output config_request_n, cfg_clock, width_sel,
		output host_data_o, host_data_oe_n, host_health_oe_n,
		input  cfg_health_n, load_complete, init_complete
	);
endinterface
`default_nettype wire

/* File: cfg_load_params.svh */
// Timing, width and depth constants of the parallel configuration link.
// Assumes a 100 MHz system clock on both ends.
`ifndef CFG_LOAD_PARAMS_SVH
`define CFG_LOAD_PARAMS_SVH
`define CLK_MHZ              100
`define WORD_W               32
`define FIFO_DEPTH           16
`define POR_DELAY_US         100
`define REQ_LOW_MIN_US       2
`define HEALTH_LOW_MIN_US    268
`define HEALTH_LOW_MAX_US    1506
`define REQ_HIGH_TO_CLK_US   1506
`define HEALTH_TO_CLK_US     2
`define RESP_MAX_NS          600
`define INIT_OSC_MIN_US      175
`define INIT_OSC_MAX_US      437
`define CFG_CLK_MAX_PER_NS   10
`define USER_CLK_WAIT_PER    4
`define USER_CLK_EDGES       8576
`define EXTRA_FALL_EDGES     2
`define CFG_HALF_CYC         4
`define IMAGE_WORDS          64
`define WIDTH_X8             2'h0
`define WIDTH_X16            2'h1
`define WIDTH_X32            2'h2
`endif

/* File: cfg_load_pkg.sv */
// Types shared by both ends of the parallel configuration link.
// Constants live in cfg_load_params.svh.
package cfg_load_pkg;
	typedef enum logic [2:0] {
		DEV_POR, DEV_RESET, DEV_LOAD, DEV_TAIL, DEV_INIT, DEV_USER
	} dev_state_t;
	typedef enum logic [2:0] {
		HOST_IDLE, HOST_REQ, HOST_WAIT, HOST_SEND, HOST_TAIL, HOST_DONE
	} host_state_t;
endpackage

/* File: parallel_config_load_ratio_one_tb.sv */
// Bench joining host and device ends over the link interface.
// Assumes the package, interface, design and checker compile first.
`timescale 1ns/10ps
`default_nettype none
module parallel_config_load_ratio_one_tb;
	logic        clk_sys_i = 1'b0;
	logic        rstn_i    = 1'b0;
	logic        usr_clk   = 1'b0;
	logic        start     = 1'b0;
	logic        use_usr   = 1'b0;
	logic        watch     = 1'b1;
	logic        src_valid = 1'b0;
	logic        img_ready = 1'b0;
	logic        gpio_oe   = 1'b0;
	logic        took      = 1'b0;
	logic        hold      = 1'b0;
	logic        init_en   = 1'b0;
	logic [1:0]  width     = 2'h0;
	logic [31:0] src_word  = 32'h0;
	logic [31:0] gpio_out  = 32'h0;
	logic        src_ready, done, fault, img_valid, user_mode, err, busy;
	logic [31:0] img_word, gpio_in;
	logic [31:0] send_q[$];
	logic [31:0] exp_q[$];
	int          mismatches = 0;
	int          samples_checked = 0;
	int          seed = 32'h615de517;
	cfg_link_if link ();
	cfg_host #(.BLIND_WAIT_CYC(100)) u_cfg_host (
		.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .link(link.host),
		.start_i(start), .width_sel_i(width), .watch_health_i(watch),
		.hold_health_i(hold), .src_word_i(src_word),
		.src_valid_i(src_valid), .src_ready_o(src_ready), .busy_o(busy),
		.done_o(done), .fault_o(fault));
	cfg_device #(.POR_CYC(20), .HEALTH_MIN_CYC(50), .INIT_OSC_CYC(40),
		.USER_EDGES(10)) u_cfg_device (
		.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .link(link.device),
		.use_user_clock_i(use_usr), .init_done_en_i(init_en),
		.user_init_clock_i(usr_clk), .image_word_o(img_word),
		.image_valid_o(img_valid), .image_ready_i(img_ready),
		.gpio_out_i(gpio_out), .gpio_oe_i(gpio_oe), .gpio_in_o(gpio_in),
		.user_mode_o(user_mode), .error_o(err));
	cfg_link_chk u_cfg_link_chk (
		.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
		.config_request_n(link.config_request_n),
		.cfg_clock(link.cfg_clock), .cfg_health_n(link.cfg_health_n),
		.load_complete(link.load_complete),
		.init_complete(link.init_complete),
		.host_data_oe_n(link.host_data_oe_n),
		.dev_data_oe_n(link.dev_data_oe_n),
		.host_health_oe_n(link.host_health_oe_n),
		.dev_init_done_oe_n(link.dev_init_done_oe_n));
	always #5 clk_sys_i = ~clk_sys_i;
	always #40 usr_clk = ~usr_clk;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Drain side: every word leaving the FIFO against the model
	always @(negedge clk_sys_i) begin
		took = src_valid && src_ready;
		if (img_valid === 1'b1 && img_ready)
			check(img_word, exp_q.pop_front());
	end
	// Word source and random drain stall
	always @(posedge clk_sys_i) begin
		if (took)
			void'(send_q.pop_front());
		src_valid <= send_q.size() > 0;
		if (send_q.size() > 0)
			src_word <= send_q[0];
		img_ready <= ($random(seed) % 4) != 0;
	end
	task automatic load(input int i);
		logic [31:0] w;
		logic [31:0] mask;
		int n;
		mask = (i % 3 == 0) ? 32'hff : (i % 3 == 1) ? 32'hffff : 32'hffffffff;
		@(posedge clk_sys_i);
		width <= 2'(i % 3);
		use_usr <= (i == 3);
		watch <= (i != 2);
		init_en <= (i != 0);
		for (int k = 0; k < 64; k++) begin
			w = $random(seed);
			send_q.push_back(w);
			exp_q.push_back(w & mask);
		end
		start <= 1'b1;
		@(posedge clk_sys_i);
		start <= 1'b0;
		repeat (60) @(negedge clk_sys_i);
		check(32'(link.load_complete), 32'h0);
		check(32'(link.cfg_health_n), 32'h0);
		check(32'(busy), 32'h1);
		if (i == 1) begin
			@(posedge clk_sys_i);
			hold <= 1'b1;
			repeat (330) @(negedge clk_sys_i);
			check(32'(link.cfg_health_n), 32'h0);
			check(32'(link.host_data_oe_n), 32'h1);
			@(posedge clk_sys_i);
			hold <= 1'b0;
		end
		n = 0;
		while (user_mode !== 1'b1 && n < 4000) begin
			@(posedge clk_sys_i);
			n++;
		end
		check(32'(n < 4000), 32'h1);
		@(negedge clk_sys_i);
		check(32'(busy), 32'h0);
		check(32'(link.load_complete), 32'h1);
		check(32'(link.init_complete), 32'h1);
		check(32'(link.cfg_health_n), 32'h1);
		check({30'h0, err, fault}, 32'h0);
		check(32'(done), 32'h1);
		check(32'(exp_q.size()), 32'h0);
		@(posedge clk_sys_i);
		gpio_out <= $random(seed);
		gpio_oe <= 1'b1;
		repeat (8) @(negedge clk_sys_i);
		check(link.data, gpio_out);
		check(gpio_in, gpio_out);
		@(posedge clk_sys_i);
		gpio_oe <= 1'b0;
	endtask
	initial begin
		repeat (16) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		repeat (2) @(negedge clk_sys_i);
		check(32'(link.cfg_health_n), 32'h0);
		check(32'(link.load_complete), 32'h0);
		for (int i = 0; i < 4; i++)
			load(i);
		conclude();
	end
	// Watchdog for a hung load
	initial begin
		repeat (25000) @(posedge clk_sys_i);
		mismatches++;
		conclude();
	end
endmodule
`default_nettype wire
